// ---- rtl/ceau_unit.sv ----
// Effective-address and branch-target unit of the core.
// Assumes the core presents a whole instruction with its operand bytes in one
// cycle on i_req, and for bit test and branch the already fetched operand byte.
//
// How it works
// - relative branch adds offset only when true
// - relative reach minus 126 to plus 129
// - no-offset index uses index register directly
// - byte offset adds index and byte unsigned
// - word offset adds index and word unsigned
// - bit modify takes bit and direct address
// - bit branch tests polarity, adds byte three
// - bit branch reach minus 125 to 130
// - tested bit always copied into carry
// - inherent decoded from opcode, one byte
`timescale 1ns/1ps

module ceau_unit
  import ceau_pkg::*;
(
  input  wire logic      i_clock,   // Core bus clock, 25 MHz.
  input  wire logic      i_reset_n, // Asynchronous reset, active low.
  input  wire logic      i_valid,   // Instruction present on i_req.
  input  wire ceau_req_t i_req,     // Instruction and operands.
  output logic           o_valid,   // Result valid, one cycle.
  output ceau_res_t      o_res      // Registered result.
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Branch target: address after the whole instruction plus signed offset.
  // The 16-bit add wraps, as the program counter does.
  function automatic logic [15:0] ceau_target(input logic [15:0] pc,
                                              input logic [1:0]  len,
                                              input logic [7:0]  off);
    logic [15:0] nxt;
    nxt = pc + {14'h0000, len};
    return nxt + {{8{off[7]}}, off};
  endfunction

  // Address after the whole instruction, used when no branch is taken.
  function automatic logic [15:0] ceau_fall(input logic [15:0] pc,
                                            input logic [1:0]  len);
    return pc + {14'h0000, len};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ceau_state_t state_q; // Registered state.
  ceau_state_t state_d; // Next state.
  logic [3:0]  hi;      // Opcode high nibble.
  logic [3:0]  lo;      // Opcode low nibble.
  logic        tbit;    // Bit under test.

  assign hi = i_req.opcode[7:4];
  assign lo = i_req.opcode[3:0];
  assign tbit = i_req.data[i_req.opcode[3:1]];

  // ----------------------------------------------------------------
  // Decode and address arithmetic
  // ----------------------------------------------------------------

  // Everything is worked out in one pass; the core sees it a cycle later.
  always_comb begin
    state_d              = state_q;
    state_d.vld          = i_valid;
    if (i_valid) begin
      state_d.res          = '0;
      state_d.res.mode     = CEAU_MODE_OTHER;
      state_d.res.length   = CEAU_LEN_2;
      state_d.res.next_pc  = ceau_fall(i_req.pc, CEAU_LEN_2);
      state_d.res.bit_num  = i_req.opcode[3:1];
      case (hi)
        CEAU_HI_BITBR: begin
          state_d.res.mode    = bit_branch_mode;
          state_d.res.length  = CEAU_LEN_3;
          state_d.res.ea      = {8'h00, i_req.byte2};
          state_d.res.carry_we = 1'b1;
          state_d.res.carry    = tbit;
          // Even opcodes branch on set, odd ones on clear.
          state_d.res.taken    = (tbit != i_req.opcode[0]);
          state_d.res.next_pc  = state_d.res.taken ?
                                 ceau_target(i_req.pc, CEAU_LEN_3, i_req.byte3) :
                                 ceau_fall(i_req.pc, CEAU_LEN_3);
        end
        CEAU_HI_BITMOD: begin
          state_d.res.mode    = bit_modify_mode;
          state_d.res.ea      = {8'h00, i_req.byte2};
          state_d.res.bit_val = ~i_req.opcode[0];
        end
        CEAU_HI_RELBR: begin
          state_d.res.mode    = pc_relative_mode;
          state_d.res.taken   = i_req.cond;
          state_d.res.next_pc = i_req.cond ?
                                ceau_target(i_req.pc, CEAU_LEN_2, i_req.byte2) :
                                ceau_fall(i_req.pc, CEAU_LEN_2);
        end
        CEAU_HI_INHA, CEAU_HI_INHX, CEAU_HI_CTL0, CEAU_HI_CTL1: begin
          state_d.res.mode    = implied_operand_mode;
          state_d.res.length  = CEAU_LEN_1;
          state_d.res.next_pc = ceau_fall(i_req.pc, CEAU_LEN_1);
        end
        CEAU_HI_IDXW: begin
          state_d.res.mode    = index_word_offset_mode;
          state_d.res.length  = CEAU_LEN_3;
          state_d.res.ea      = {i_req.byte2, i_req.byte3} + {8'h00, i_req.index};
          state_d.res.next_pc = ceau_fall(i_req.pc, CEAU_LEN_3);
        end
        CEAU_HI_IDXB, CEAU_HI_IX1RMW: begin
          state_d.res.mode    = index_byte_offset_mode;
          state_d.res.ea      = {8'h00, i_req.byte2} + {8'h00, i_req.index};
        end
        CEAU_HI_IDX0, CEAU_HI_IXRMW: begin
          state_d.res.mode    = index_no_offset_mode;
          state_d.res.length  = CEAU_LEN_1;
          state_d.res.ea      = {8'h00, i_req.index};
          state_d.res.next_pc = ceau_fall(i_req.pc, CEAU_LEN_1);
        end
        default: begin
          // Subroutine branch uses relative mode and always branches.
          // subroutine branch, condition always true
          if (lo == CEAU_LO_BSR && hi == CEAU_HI_BSR) begin
            state_d.res.mode    = pc_relative_mode;
            state_d.res.taken   = 1'b1;
            state_d.res.next_pc = ceau_target(i_req.pc, CEAU_LEN_2, i_req.byte2);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Held result stays readable after the valid pulse until the next request.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_valid = state_q.vld;
  assign o_res   = state_q.res;

endmodule

// ---- rtl/ceau_pkg.sv ----
// Package for the effective-address unit: addressing modes, opcode fields, widths.
// Assumes the surrounding core fetches opcode and operand bytes and supplies them.
package ceau_pkg;

  // ----------------------------------------------------------------
  // Widths and opcode fields
  // ----------------------------------------------------------------
  localparam int unsigned CEAU_AW        = 16;       // Address width.
  localparam int unsigned CEAU_DW        = 8;        // Data width.
  localparam logic [3:0]  CEAU_HI_BITBR  = 4'h0;     // High nibble of bit test and branch.
  localparam logic [3:0]  CEAU_HI_BITMOD = 4'h1;     // High nibble of bit set/clear.
  localparam logic [3:0]  CEAU_HI_RELBR  = 4'h2;     // High nibble of relative branches.
  localparam logic [3:0]  CEAU_HI_INHA   = 4'h4;     // Accumulator inherent column.
  localparam logic [3:0]  CEAU_HI_INHX   = 4'h5;     // Index inherent column.
  localparam logic [3:0]  CEAU_HI_IX1RMW = 4'h6;     // Read-modify-write, byte offset.
  localparam logic [3:0]  CEAU_HI_IXRMW  = 4'h7;     // Read-modify-write, no offset.
  localparam logic [3:0]  CEAU_HI_CTL0   = 4'h8;     // Control column.
  localparam logic [3:0]  CEAU_HI_CTL1   = 4'h9;     // Control column.
  localparam logic [3:0]  CEAU_HI_BSR    = 4'hA;     // Column holding the subroutine branch.
  localparam logic [3:0]  CEAU_HI_IDXW   = 4'hD;     // Register/memory, word offset.
  localparam logic [3:0]  CEAU_HI_IDXB   = 4'hE;     // Register/memory, byte offset.
  localparam logic [3:0]  CEAU_HI_IDX0   = 4'hF;     // Register/memory, no offset.
  localparam logic [3:0]  CEAU_LO_BSR    = 4'hD;     // Low nibble of subroutine branch.
  localparam logic [1:0]  CEAU_LEN_1     = 2'h1;     // One-byte instruction.
  localparam logic [1:0]  CEAU_LEN_2     = 2'h2;     // Two-byte instruction.
  localparam logic [1:0]  CEAU_LEN_3     = 2'h3;     // Three-byte instruction.
  localparam logic [15:0] CEAU_PC_RESET  = 16'h0000; // Reset value of held outputs.

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CEAU_MODE_OTHER         = 3'b000, // Mode handled elsewhere in the core.
    pc_relative_mode        = 3'b001,
    index_no_offset_mode    = 3'b010,
    index_byte_offset_mode  = 3'b011,
    index_word_offset_mode  = 3'b100,
    bit_modify_mode         = 3'b101,
    bit_branch_mode         = 3'b110,
    implied_operand_mode    = 3'b111
  } ceau_mode_t;

  // Request from the core: one whole instruction with its operand bytes.
  typedef struct packed {
    logic [7:0]  opcode;   // Opcode byte.
    logic [7:0]  byte2;    // Byte after the opcode.
    logic [7:0]  byte3;    // Third byte.
    logic [15:0] pc;       // Address of the opcode.
    logic [7:0]  index;    // Index register contents.
    logic        cond;     // Branch condition for relative mode.
    logic [7:0]  data;     // Operand byte read for bit test and branch.
  } ceau_req_t;

  // Result handed back to the core.
  typedef struct packed {
    ceau_mode_t  mode;      // Decoded addressing mode.
    logic [1:0]  length;    // Instruction length in bytes.
    logic [15:0] ea;        // Effective operand address.
    logic [15:0] next_pc;   // Next program counter.
    logic        taken;     // Branch taken.
    logic [2:0]  bit_num;   // Bit number from the opcode.
    logic        bit_val;   // Value for bit set (1) or clear (0).
    logic        carry_we;  // Carry flag write enable.
    logic        carry;     // New carry value.
  } ceau_res_t;

  // All module state.
  typedef struct packed {
    ceau_res_t res;  // Registered result.
    logic      vld;  // Result valid pulse.
  } ceau_state_t;

endpackage

// ---- tb/ceau_unit_properties.sv ----
// Port checker for the effective-address unit.
// Assumes a bind to ceau_unit and sees only its ports.
`timescale 1ns/1ps
module ceau_chk
  import ceau_pkg::*;
(
  input wire logic      i_clock,
  input wire logic      i_reset_n,
  input wire logic      i_valid,
  input wire ceau_req_t i_req,
  input wire logic      o_valid,
  input wire ceau_res_t o_res
);
  // Expected targets and addresses, formed from the request as it is taken.
  wire ceau_res_t q   = o_res;
  wire [3:0]      hi  = i_req.opcode[7:4];
  wire            v   = i_valid;
  wire [15:0]     p2  = i_req.pc + 16'h0002;
  wire [15:0]     t2  = p2 + {{8{i_req.byte2[7]}}, i_req.byte2};
  wire [15:0]     t3  = p2 + 16'h0001 + {{8{i_req.byte3[7]}}, i_req.byte3};
  wire [15:0]     x0  = {8'h00, i_req.index};
  wire [15:0]     x1  = x0 + {8'h00, i_req.byte2};
  wire [15:0]     x2  = x0 + {i_req.byte2, i_req.byte3};
  wire            bt  = i_req.data[i_req.opcode[3:1]];
  wire            hit = bt ^ i_req.opcode[0];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_answer_next: assert property (v |=> o_valid)
    else $error("result missing after a request");
  a_no_extra: assert property (!v |=> !o_valid && $stable(q))
    else $error("result changed without a request");
  a_rel_taken: assert property (v && hi == 4'h2 && i_req.cond |=> q.next_pc == $past(t2))
    else $error("relative target wrong");
  a_rel_skip: assert property (v && hi == 4'h2 && !i_req.cond |=> q.next_pc == $past(p2))
    else $error("relative branch taken on false condition");
  a_ix_direct: assert property (v && hi[2:0] == 3'h7 |=> q.ea == $past(x0) && q.length == 2'h1)
    else $error("no-offset address wrong");
  a_ix_byte: assert property (v && hi[2:0] == 3'h6 |=> q.ea == $past(x1))
    else $error("byte-offset address wrong");
  a_ix_word: assert property (v && hi == 4'hD |=> q.ea == $past(x2) && q.length == 2'h3)
    else $error("word-offset address wrong");
  a_bit_modify: assert property (v && hi == 4'h1 |=> q.ea == {8'h00, $past(i_req.byte2)})
    else $error("bit modify address wrong");
  a_bit_target: assert property (v && hi == 4'h0 && hit |=> q.taken && q.next_pc == $past(t3))
    else $error("bit branch target wrong");
  a_carry_copy: assert property (v && hi == 4'h0 |=> q.carry_we && q.carry == $past(bt))
    else $error("tested bit not in carry");
  a_inh_length: assert property (v && hi inside {4'h4, 4'h5, 4'h8, 4'h9} |=> q.length == 2'h1)
    else $error("inherent length wrong");
  a_rel_mode: assert property (v && hi == 4'h2 |=> q.mode == pc_relative_mode)
    else $error("relative mode code wrong");
  a_bit_mode: assert property (v && hi == 4'h0 |=> q.mode == bit_branch_mode && q.length == 2'h3)
    else $error("bit branch mode code wrong");
endmodule

// ---- tb/ceau_mem_model.sv ----
// Operand memory on the core bus: one byte for each direct address.
// Assumes the bench presents the direct address and takes the byte back.
`timescale 1ns/1ps
module ceau_mem_model
  import ceau_pkg::*;
(
  input  wire logic [7:0] i_addr, // Direct address, lowest 256 locations.
  output logic      [7:0] o_data  // Byte stored there.
);
  // Contents are scrambled so each bit number meets both values.
  assign o_data = i_addr ^ 8'hC3 ^ {i_addr[3:0], i_addr[7:4]};
endmodule

// ---- tb/test_cpu_effective_address_unit.sv ----
// Self-checking bench for the effective-address unit.
// Assumes the package, the unit, the checker and the memory model are compiled first.
`timescale 1ns/1ps
module test_cpu_effective_address_unit;
  import ceau_pkg::*;
  logic        i_clock;
  logic        i_reset_n;
  logic        vld;
  logic        ov;
  ceau_req_t   rq;
  ceau_res_t   q;
  logic [7:0]  md;
  logic [15:0] pc = 16'h0100;
  int          error_cnt;
  int          samples_checked;
  ceau_unit dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_valid(vld), .i_req(rq),
    .o_valid(ov), .o_res(q));
  ceau_mem_model mem (.i_addr(rq.byte2), .o_data(md));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One request from a falling edge; its answer is read one cycle later.
  task automatic go(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
                    input logic c);
    rq.opcode = op;
    rq.byte2 = b2;
    rq.byte3 = b3;
    rq.cond = c;
    rq.pc = pc;
    #1 rq.data = md;
    vld = 1'b1;
    @(negedge i_clock);
    vld = 1'b0;
    chk({15'h0000, ov}, 16'h0001);
  endtask
  task automatic t_rel();
    go(8'h20, 8'h7F, 8'h00, 1'b1);
    chk(q.next_pc, pc + 16'h0081);
    go(8'h27, 8'h80, 8'h00, 1'b1);
    chk(q.next_pc, pc - 16'h007E);
    go(8'h26, 8'h7F, 8'h00, 1'b0);
    chk({q.next_pc[14:0], q.taken}, {pc[14:0] + 15'h0002, 1'b0});
    go(8'hAD, 8'h10, 8'h00, 1'b0);
    chk(q.next_pc, pc + 16'h0012);
    pc = 16'hFFF0;
    go(8'h2F, 8'h7F, 8'h00, 1'b1);
    chk(q.next_pc, 16'h0071);
    pc = 16'h0100;
  endtask
  task automatic t_index();
    rq.index = 8'hFF;
    go(8'hF6, 8'h00, 8'h00, 1'b0);
    chk({q.length, q.ea[13:0]}, 16'h40FF);
    chk({13'h0000, q.mode}, {13'h0000, index_no_offset_mode});
    go(8'hE6, 8'hFF, 8'h00, 1'b0);
    chk(q.ea, 16'h01FE);
    chk({13'h0000, q.mode}, {13'h0000, index_byte_offset_mode});
    go(8'hD6, 8'hFF, 8'hC0, 1'b0);
    chk({q.length, q.ea[13:0]}, 16'hC0BF);
    chk({13'h0000, q.mode}, {13'h0000, index_word_offset_mode});
  endtask
  // Every bit number with both polarities, forward and backward offsets.
  task automatic t_bits();
    logic [7:0] op;
    logic       t;
    for (int k = 0; k < 16; k++) begin
      op = 8'h10 | 8'(k);
      go(op, 8'hA5, 8'h00, 1'b0);
      chk({q.ea[11:0], q.bit_num, q.bit_val}, {12'h0A5, op[3:1], ~op[0]});
      chk({13'h0000, q.mode}, {13'h0000, bit_modify_mode});
      op = 8'(k);
      go(op, 8'(8'h30 + k), k[1] ? 8'h7F : 8'h80, 1'b0);
      t = rq.data[op[3:1]] ^ op[0];
      chk({14'h0000, q.carry_we, q.carry}, {14'h0001, rq.data[op[3:1]]});
      chk(q.next_pc, pc + 16'h0003 + (t ? {{8{rq.byte3[7]}}, rq.byte3} : 16'h0000));
    end
  endtask
  task automatic t_inh();
    logic [7:0] ops [4] = '{8'h40, 8'h5F, 8'h83, 8'h9D};
    foreach (ops[i]) begin
      go(ops[i], 8'h55, 8'h66, 1'b0);
      chk(q.next_pc + {q.length, 14'h0000}, pc + 16'h4001);
      chk({13'h0000, q.mode}, {13'h0000, implied_operand_mode});
    end
  endtask
  // Back-to-back requests, an idle cycle holding the result, then a reset.
  task automatic t_hold();
    rq.opcode = 8'hF0;
    rq.index = 8'h12;
    #1 vld = 1'b1;
    @(negedge i_clock);
    rq.index = 8'h34;
    chk(q.ea, 16'h0012);
    @(negedge i_clock);
    vld = 1'b0;
    chk(q.ea, 16'h0034);
    rq.index = 8'h56;
    @(negedge i_clock);
    chk({ov, q.ea[14:0]}, 16'h0034);
    i_reset_n = 1'b0;
    @(negedge i_clock);
    chk(q.ea, 16'h0000);
    i_reset_n = 1'b1;
  endtask
  initial begin
    i_reset_n = 1'b0;
    vld = 1'b0;
    rq = '0;
    repeat (3) @(negedge i_clock);
    i_reset_n = 1'b1;
    t_rel();
    t_index();
    t_bits();
    t_inh();
    t_hold();
    close_out();
  end
  // Cuts a hang short; the tests need well under 200 cycles.
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule
bind ceau_unit ceau_chk u_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_valid(i_valid),
  .i_req(i_req), .o_valid(o_valid), .o_res(o_res));
